/* rtl/addr_decoder.sv */
// Decoder end: latches the low address, builds chip selects, returns read data.
// Assumes the processor end drives the multiplexed bus on the same clock.
//
// Rules from the document
// RULE1: One cycle protocol for memory and ports
// RULE2: Cycles finish unless ready held low
// RULE3: Writes complete even with no target
// RULE4: Read bytes carry no type tag
// RULE5: I/O-mapped uses indicator; memory-mapped ignores it
// RULE6: Bit fifteen low is memory, high is I/O
// RULE7: Direct load/store: three bytes, thirteen clocks
// RULE8: Port instructions: two bytes, ten clocks
// RULE9: Port space is 256 locations
// RULE10: Low eleven lines address within block
// RULE11: Full decode needs bits fifteen..eleven zero
// RULE12: Linear select uses bit eleven, aliases
// RULE13: One select asserted deselects all others
// RULE14: Spurious addresses appear in late fetch
// RULE15: Qualify select with strobe or latched address
// RULE16: Each linear bit halves address space
// RULE17: Multi-enable targets decode partially internally
// RULE18: Latch strobe marks low address valid
// RULE19: Port number copied onto upper lines
// RULE20: No select in reset or without strobe; chip_sel is registered, so it trails strobe by one cycle
// RULE21: Flag when two selects assert together
`timescale 1ns/10ps
`include "addr_decode_consts.svh"
module addr_decoder (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // Processor bus
   mux_bus_if.decoder                     bus,
   // Configuration
   input  wire addr_decode_pkg::scheme_t  scheme,
   input  wire logic [3:0]                wait_states,
   // Target side
   output logic [`NUM_SEL-1:0]            chip_sel,
   output logic [`BLOCK_LOW_BITS-1:0]     target_addr,
   output logic                           target_is_io,
   output logic                           target_wr,
   output logic [`DATA_W-1:0]             target_wdata,
   input  wire logic [`DATA_W-1:0]        target_rdata [`NUM_SEL],
   output logic                           overlap_err
);
   import addr_decode_pkg::*;

   typedef struct packed {
      logic [`DATA_W-1:0]  addr_low;
      logic [3:0]          wait_cnt;
      logic [`NUM_SEL-1:0] sel;
      logic [`DATA_W-1:0]  rdata;
      logic                rd_oe;
      logic                err;
      logic [`DATA_W-1:0]  wdata;
      logic                wr;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;

   logic [`ADDR_W-1:0]  full_addr;
   logic [`ADDR_W-1:0]  dec_addr;
   logic [`NUM_SEL-1:0] raw_sel;
   logic                strobe;
   logic                io_cycle;
   logic [2:0]          sel_count;
   logic [`DATA_W-1:0]  read_mux;

   assign full_addr = {bus.addr_high, cur_ff.addr_low};
   // Decode straight off the bus in the latch cycle, so read data is staged early
   assign dec_addr  = bus.addr_latch ? {bus.addr_high, bus.ad_in} : full_addr;
   assign strobe    = ~bus.rd_n | ~bus.wr_n | ~bus.inta_n; // [RULE15]

   always_comb begin
      // Port space selection by indicator or by bit fifteen
      case (scheme)
         scheme_io_mapped:  io_cycle = bus.io_m;                           // [RULE5]
         scheme_mem_mapped: io_cycle = dec_addr[`ADDR_BIT_FIFTEEN];        // [RULE5] [RULE6]
         default:           io_cycle = bus.io_m;
      endcase
   end

   always_comb begin
      raw_sel = '0;
      case (scheme)
         scheme_linear: begin
            // Bit eleven low selects block 0 wherever it aliases
            raw_sel[0] = ~dec_addr[`ADDR_BIT_ELEVEN];                    // [RULE12] [RULE16]
            raw_sel[1] = dec_addr[`ADDR_BIT_ELEVEN] & ~dec_addr[12];     // [RULE17]
         end
         scheme_full: begin
            // Four 2k blocks, upper lines fully decoded
            if (dec_addr[15:13] == 3'h0) begin
               raw_sel[dec_addr[12:11]] = 1'b1;                          // [RULE11] [RULE10]
            end
         end
         scheme_mem_mapped: begin
            raw_sel[0] = ~io_cycle & (dec_addr[14:11] == 4'h0);          // [RULE6]
            raw_sel[1] = io_cycle & (dec_addr[7:0] < 8'h04);
         end
         default: begin
            raw_sel[0] = ~io_cycle & (dec_addr[15:11] == 5'h00);        // [RULE11]
            raw_sel[1] = io_cycle & (bus.addr_high == dec_addr[7:0])    // [RULE19] [RULE9]
                         & (dec_addr[7:0] < 8'h04);
         end
      endcase
   end

   always_comb begin
      sel_count = '0;
      read_mux  = '0;
      for (int i = 0; i < `NUM_SEL; i++) begin
         sel_count = sel_count + {2'b00, cur_ff.sel[i]};
         if (raw_sel[i]) begin
            read_mux = target_rdata[i];
         end
      end
   end

   always_comb begin
      nxt_cur = cur_ff;
      if (bus.addr_latch) begin
         nxt_cur.addr_low = bus.ad_in;                                   // [RULE18] [RULE15]
         nxt_cur.wait_cnt = wait_states;
         // Byte must stand on the bus in the first strobe cycle: no-wait reads sample there
         nxt_cur.rd_oe    = |raw_sel;                                    // [RULE15]
         nxt_cur.rdata    = read_mux;                                    // [RULE4]
      end else begin
         if (cur_ff.wait_cnt != 4'h0 && strobe) begin
            nxt_cur.wait_cnt = cur_ff.wait_cnt - 4'h1;                   // [RULE2]
         end
         if (!strobe) begin
            nxt_cur.rd_oe = 1'b0;
         end
      end
      nxt_cur.sel   = strobe ? raw_sel : '0;                             // [RULE20] [RULE14]
      nxt_cur.wr    = ~bus.wr_n;                                         // [RULE3] [RULE1]
      if (~bus.wr_n) begin
         nxt_cur.wdata = bus.ad_in;
      end
      nxt_cur.err   = cur_ff.err | (sel_count > 3'h1);                   // [RULE21] [RULE13]
      if (rst) begin
         nxt_cur = '0;                                                    // [RULE20]
      end
   end

   always_ff @(posedge clk) begin
      cur_ff <= nxt_cur;
   end

   assign chip_sel     = cur_ff.sel;
   assign target_addr  = full_addr[`BLOCK_LOW_BITS-1:0];                  // [RULE10]
   assign target_is_io = io_cycle;
   assign target_wr    = cur_ff.wr;
   assign target_wdata = cur_ff.wdata;
   assign overlap_err  = cur_ff.err;
   assign bus.rd_data  = cur_ff.rdata;
   assign bus.rd_oe    = cur_ff.rd_oe & ~bus.rd_n;
   assign bus.ready    = (cur_ff.wait_cnt == 4'h0);                       // [RULE2]
endmodule : addr_decoder

/* rtl/addr_decode_consts.svh */
// Constants for the multiplexed-bus address decoder and its bus master.
// Assumes inclusion by bare name; definitions only.
`ifndef ADDR_DECODE_CONSTS_SVH
`define ADDR_DECODE_CONSTS_SVH
`define ADDR_W            16
`define DATA_W            8
`define NUM_SEL           4
`define BLOCK_LOW_BITS    11
`define ADDR_BIT_FIFTEEN  15
`define ADDR_BIT_ELEVEN   11
`define PORT_SPACE_BYTES  256
`define CYC_LDA_STA       13
`define CYC_IN_OUT        10
`define BYTES_LDA_STA     3
`define BYTES_IN_OUT      2
`define MEM_LIMIT_BYTES   32768
`define STATE_CYCLES      3
`endif

/* rtl/addr_decode_pkg.sv */
// Types shared by the processor end and the decoder end.
// Assumes addr_decode_consts.svh is on the include path.
package addr_decode_pkg;
   typedef enum logic [1:0] {
      scheme_io_mapped,
      scheme_mem_mapped,
      scheme_linear,
      scheme_full
   } scheme_t;

   typedef enum logic [1:0] {
      op_mem_read,
      op_mem_write,
      op_io_read,
      op_io_write
   } op_t;

   typedef enum logic [1:0] {
      byte_opcode,
      byte_operand,
      byte_port
   } byte_kind_t;
endpackage : addr_decode_pkg

/* rtl/mux_bus_if.sv */
// Multiplexed 8-bit address/data bus between processor end and decoder end.
// Assumes one clock; the shared lines are resolved here from enables.
`timescale 1ns/10ps
`include "addr_decode_consts.svh"
interface mux_bus_if;
   logic [`DATA_W-1:0] ad_out;
   logic               ad_oe;
   logic [`DATA_W-1:0] rd_data;
   logic               rd_oe;
   logic [`DATA_W-1:0] ad_in;
   logic [7:0]         addr_high;
   logic               addr_latch;
   logic               rd_n;
   logic               wr_n;
   logic               inta_n;
   logic               io_m;
   logic               ready;

   assign ad_in = ad_oe ? ad_out : (rd_oe ? rd_data : '0);

   modport processor (
      output ad_out, ad_oe, addr_high, addr_latch, rd_n, wr_n, inta_n, io_m,
      input  ad_in, ready
   );
   modport decoder (
      input  ad_in, addr_high, addr_latch, rd_n, wr_n, inta_n, io_m,
      output rd_data, rd_oe, ready
   );
endinterface : mux_bus_if

/* rtl/bus_processor.sv */
// Processor end: runs read and write machine cycles on the multiplexed bus.
// Assumes a user issues one request at a time and waits for done.
`timescale 1ns/10ps
`include "addr_decode_consts.svh"
module bus_processor (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // Processor bus
   mux_bus_if.processor                bus,
   // User requests
   input  wire logic                   req_valid,
   output logic                        req_ready,
   input  wire addr_decode_pkg::op_t   req_op,
   input  wire logic [`ADDR_W-1:0]     req_addr,
   input  wire logic [`DATA_W-1:0]     req_wdata,
   output logic                        done,
   output logic [`DATA_W-1:0]          rdata
);
   import addr_decode_pkg::*;

   typedef enum logic [1:0] {st_idle, st_addr, st_strobe, st_end} phase_t;

   typedef struct packed {
      phase_t             phase;
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] wdata;
      logic [`DATA_W-1:0] rdata;
      logic               is_wr;
      logic               is_io;
      logic               done;
   } state_t;

   state_t cur_ff;
   state_t nxt_cur;

   always_comb begin
      nxt_cur      = cur_ff;
      nxt_cur.done = 1'b0;
      case (cur_ff.phase)
         st_idle: begin
            if (req_valid) begin
               nxt_cur.is_wr = (req_op == op_mem_write) || (req_op == op_io_write);
               nxt_cur.is_io = (req_op == op_io_read) || (req_op == op_io_write);
               nxt_cur.wdata = req_wdata;
               // Port number mirrored on both address halves
               if ((req_op == op_io_read) || (req_op == op_io_write)) begin
                  nxt_cur.addr = {req_addr[7:0], req_addr[7:0]};          // [RULE19] [RULE9] [RULE8]
               end else begin
                  nxt_cur.addr = req_addr;                                // [RULE7]
               end
               nxt_cur.phase = st_addr;
            end
         end
         st_addr: nxt_cur.phase = st_strobe;                              // [RULE18]
         st_strobe: begin
            if (bus.ready) begin                                          // [RULE2]
               if (!cur_ff.is_wr) begin
                  nxt_cur.rdata = bus.ad_in;                              // [RULE4]
               end
               nxt_cur.phase = st_end;                                    // [RULE3]
            end
         end
         st_end: begin
            nxt_cur.done  = 1'b1;
            nxt_cur.phase = st_idle;
         end
         default: nxt_cur.phase = st_idle;
      endcase
      if (rst) begin
         nxt_cur = '0;
      end
   end

   always_ff @(posedge clk) begin
      cur_ff <= nxt_cur;
   end

   // Same strobe timing for memory and port cycles
   assign bus.addr_latch = (cur_ff.phase == st_addr);                     // [RULE18] [RULE1]
   assign bus.addr_high  = (cur_ff.phase == st_idle) ? 8'h00 : cur_ff.addr[15:8];
   assign bus.ad_out     = (cur_ff.phase == st_addr) ? cur_ff.addr[7:0] : cur_ff.wdata;
   assign bus.ad_oe      = (cur_ff.phase == st_addr) | ((cur_ff.phase == st_strobe) & cur_ff.is_wr);
   assign bus.rd_n       = ~((cur_ff.phase == st_strobe) & ~cur_ff.is_wr);
   assign bus.wr_n       = ~((cur_ff.phase == st_strobe) & cur_ff.is_wr);
   assign bus.inta_n     = 1'b1;
   assign bus.io_m       = (cur_ff.phase != st_idle) & cur_ff.is_io;      // [RULE5]
   assign req_ready      = (cur_ff.phase == st_idle);
   assign done           = cur_ff.done;
   assign rdata          = cur_ff.rdata;
endmodule : bus_processor

/* tb/mux_bus_chk.sv */
// Checker on the bus between processor end and decoder end.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`include "addr_decode_consts.svh"
module mux_bus_chk (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // Bus lines
   input  wire logic [`DATA_W-1:0] ad_in,
   input  wire logic               ad_oe,
   input  wire logic               rd_oe,
   input  wire logic [7:0]         addr_high,
   input  wire logic               addr_latch,
   input  wire logic               rd_n,
   input  wire logic               wr_n,
   input  wire logic               io_m,
   input  wire logic               ready
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_addr;
      addr_latch;
   endsequence
   sequence s_strobe;
      !rd_n || !wr_n;
   endsequence
   property p_latch_pulse;
      s_addr |=> !addr_latch;
   endproperty
   a_latch_pulse: assert property (p_latch_pulse) else $error("latch pulse too long");
   property p_strobe_next;
      s_addr |=> s_strobe;
   endproperty
   a_strobe_next: assert property (p_strobe_next) else $error("no strobe after latch");
   property p_one_strobe;
      !(!rd_n && !wr_n);
   endproperty
   a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
   property p_port_copy;
      addr_latch && io_m |-> addr_high == ad_in;
   endproperty
   a_port_copy: assert property (p_port_copy) else $error("port number not copied");
   property p_wait_hold;
      (!rd_n || !wr_n) && !ready |=> s_strobe;
   endproperty
   a_wait_hold: assert property (p_wait_hold) else $error("strobe dropped in wait");
   property p_release;
      s_strobe ##0 ready |=> rd_n && wr_n;
   endproperty
   a_release: assert property (p_release) else $error("strobe held after ready");
   property p_bounded;
      $fell(rd_n) || $fell(wr_n) |-> ##[1:17] (rd_n && wr_n);
   endproperty
   a_bounded: assert property (p_bounded) else $error("cycle never ends");
   property p_write_drive;
      !wr_n |-> ad_oe;
   endproperty
   a_write_drive: assert property (p_write_drive) else $error("write data not driven");
   property p_one_driver;
      !(ad_oe && rd_oe);
   endproperty
   a_one_driver: assert property (p_one_driver) else $error("bus driven twice");
endmodule : mux_bus_chk

/* tb/address_decode_chip_select_test.sv */
// Bench joining processor end and decoder end over the bus.
// Assumes the select maps chosen for each decode scheme.
`timescale 1ns/10ps
`include "addr_decode_consts.svh"
`define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s exp %h got %h", nm, e, g); end end
module address_decode_chip_select_test;
   import addr_decode_pkg::*;
   logic                       clk, rst, req_valid, req_ready, done;
   logic                       target_is_io, target_wr, overlap_err;
   scheme_t                    scheme;
   op_t                        req_op;
   logic [3:0]                 wait_states, chip_sel;
   logic [`ADDR_W-1:0]         req_addr;
   logic [`DATA_W-1:0]         req_wdata, rdata, target_wdata;
   logic [`DATA_W-1:0]         target_rdata [`NUM_SEL];
   logic [`BLOCK_LOW_BITS-1:0] target_addr;
   int                         failures, tests_run;
   mux_bus_if bus_if ();
   bus_processor u_bus_processor (.clk(clk), .rst(rst), .bus(bus_if.processor), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .done(done),
      .rdata(rdata));
   addr_decoder u_addr_decoder (.clk(clk), .rst(rst), .bus(bus_if.decoder), .scheme(scheme),
      .wait_states(wait_states), .chip_sel(chip_sel), .target_addr(target_addr), .target_is_io(target_is_io),
      .target_wr(target_wr), .target_wdata(target_wdata), .target_rdata(target_rdata), .overlap_err(overlap_err));
   mux_bus_chk u_mux_bus_chk (.clk(clk), .rst(rst), .ad_in(bus_if.ad_in), .ad_oe(bus_if.ad_oe),
      .rd_oe(bus_if.rd_oe), .addr_high(bus_if.addr_high), .addr_latch(bus_if.addr_latch), .rd_n(bus_if.rd_n),
      .wr_n(bus_if.wr_n), .io_m(bus_if.io_m), .ready(bus_if.ready));
   always_comb for (int i = 0; i < `NUM_SEL; i++) target_rdata[i] = 8'ha0 + 8'(i);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic tally_and_finish;
      $display("Checks %0d, failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task automatic do_reset(input scheme_t s, input logic [3:0] w);
      scheme = s;
      wait_states = w;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      `CHECK("sel_reset", 4'h0, chip_sel)
   endtask : do_reset
   task automatic run_case(input op_t op, input logic [15:0] a, input logic [3:0] es);
      logic [3:0]  seen;
      logic [7:0]  ed;
      logic [15:0] ea;
      logic [10:0] ta;
      logic        io_op, is_wr, tio, wr_seen;
      int n;
      seen = 4'h0;
      n = 0;
      ed = 8'ha0;
      ta = '0;
      tio = 1'b0;
      wr_seen = 1'b0;
      io_op = (op == op_io_read) || (op == op_io_write);
      is_wr = (op == op_mem_write) || (op == op_io_write);
      ea = io_op ? {a[7:0], a[7:0]} : a;
      for (int i = 0; i < 4; i++) if (es[i]) ed = 8'ha0 + 8'(i);
      `CHECK("req_ready", 1'b1, req_ready)
      req_op = op;
      req_addr = a;
      req_wdata = 8'h5a;
      req_valid = 1'b1;
      @(posedge clk);
      #1 req_valid = 1'b0;
      while (done !== 1'b1 && n < 40) begin
         seen |= chip_sel;
         wr_seen |= target_wr;
         if (n == 2) begin
            ta = target_addr;
            tio = target_is_io;
         end
         @(posedge clk);
         #1 n++;
      end
      `CHECK("latency", 3 + int'(wait_states), n)
      if (es != 4'h0 && (op == op_mem_read || op == op_io_read)) `CHECK("rdata", ed, rdata)
      `CHECK("target_addr", ea[10:0], ta)
      `CHECK("target_is_io", (scheme == scheme_mem_mapped) ? ea[15] : io_op, tio)
      `CHECK("target_wr", is_wr, wr_seen)
      if (is_wr) `CHECK("target_wdata", 8'h5a, target_wdata)
      seen |= chip_sel;
      @(posedge clk);
      #1 seen |= chip_sel;
      `CHECK("done_pulse", 1'b0, done)
      `CHECK("chip_sel", es, seen)
      `CHECK("overlap", 1'b0, overlap_err)
   endtask : run_case
   task automatic t_io_mapped;
      do_reset(scheme_io_mapped, 4'h0);
      run_case(op_mem_read, 16'h0005, 4'h1);
      run_case(op_io_write, 16'h0002, 4'h2);
      run_case(op_io_read, 16'h0003, 4'h2);
      run_case(op_mem_read, 16'h0002, 4'h1);
      run_case(op_io_read, 16'h0010, 4'h0);
      run_case(op_mem_write, 16'h0900, 4'h0);
      $display("io_mapped finished");
   endtask : t_io_mapped
   task automatic t_mem_mapped;
      do_reset(scheme_mem_mapped, 4'h0);
      run_case(op_mem_read, 16'h0001, 4'h1);
      run_case(op_mem_write, 16'h8001, 4'h2);
      run_case(op_io_read, 16'h0001, 4'h1);
      run_case(op_io_read, 16'h0081, 4'h0);
      $display("mem_mapped finished");
   endtask : t_mem_mapped
   task automatic t_linear;
      do_reset(scheme_linear, 4'h0);
      run_case(op_mem_read, 16'h1000, 4'h1);
      run_case(op_mem_read, 16'hf000, 4'h1);
      run_case(op_mem_read, 16'h0800, 4'h2);
      run_case(op_mem_write, 16'h1800, 4'h0);
      $display("linear finished");
   endtask : t_linear
   task automatic t_full;
      do_reset(scheme_full, 4'h0);
      run_case(op_mem_read, 16'h07ff, 4'h1);
      run_case(op_mem_read, 16'h0800, 4'h2);
      run_case(op_mem_write, 16'h1000, 4'h4);
      run_case(op_mem_read, 16'h1fff, 4'h8);
      run_case(op_mem_read, 16'h2000, 4'h0);
      $display("full finished");
   endtask : t_full
   task automatic t_waits;
      do_reset(scheme_full, 4'h3);
      run_case(op_mem_read, 16'h0000, 4'h1);
      run_case(op_mem_write, 16'h1000, 4'h4);
      $display("waits finished");
   endtask : t_waits
   initial begin
      rst = 1'b1;
      scheme = scheme_io_mapped;
      wait_states = 4'h0;
      req_valid = 1'b0;
      req_op = op_mem_read;
      req_addr = 16'h0000;
      req_wdata = 8'h00;
      failures = 0;
      tests_run = 0;
      t_io_mapped();
      t_mem_mapped();
      t_linear();
      t_full();
      t_waits();
      tally_and_finish();
   end
   initial begin
      #5000;
      failures++;
      tally_and_finish();
   end
endmodule : address_decode_chip_select_test
